// file: core/expander_pkg.sv
// constants, command codes and state type of the dual-bank i/o expander
package expander_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 8;
    localparam int BANK_REGS = 6;
    localparam int BIT_COUNT_W = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    // ------------------------------------------------------------
    // command byte codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_NORMAL_OUTPUT_LEVEL = 8'h00;
    localparam logic [7:0] CMD_NORMAL_RISE_MASK = 8'h01;
    localparam logic [7:0] CMD_NORMAL_FALL_MASK = 8'h02;
    localparam logic [7:0] CMD_SUSPEND_OUTPUT_LEVEL = 8'h03;
    localparam logic [7:0] CMD_SUSPEND_RISE_MASK = 8'h04;
    localparam logic [7:0] CMD_SUSPEND_FALL_MASK = 8'h05;
    localparam logic [7:0] CMD_PIN_LEVEL_READBACK = 8'h06;
    localparam logic [7:0] CMD_RESAMPLE_STRAPS = 8'h07;
    localparam logic [7:0] CMD_SOFT_RESET = 8'h08;
    localparam logic [7:0] CMD_MAKER_IDENT = 8'hFE;

    // ------------------------------------------------------------
    // index of each register inside the bank array
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_NORMAL_OUTPUT_LEVEL = 3'h0;
    localparam logic [2:0] IDX_NORMAL_RISE_MASK = 3'h1;
    localparam logic [2:0] IDX_NORMAL_FALL_MASK = 3'h2;
    localparam logic [2:0] IDX_SUSPEND_OUTPUT_LEVEL = 3'h3;
    localparam logic [2:0] IDX_SUSPEND_RISE_MASK = 3'h4;
    localparam logic [2:0] IDX_SUSPEND_FALL_MASK = 3'h5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LEVEL_RST_DRIVE_LOW = 8'h00;
    localparam logic [7:0] LEVEL_RST_RELEASED = 8'hFF;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [6:0] OWN_ADDR_RST = 7'h00;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_DATA,
        ST_DATA_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } state_t;

endpackage

// file: core/smb_events_if.sv
// bus events passed from the serial front end to the register core
`timescale 1ns/1ps
`default_nettype none

interface smb_events_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;

    modport front (output scl_rise, output scl_fall, output start, output stop, output sda);
    modport core (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

`default_nettype wire

// file: core/smb_frontend.sv
// synchronises the serial clock and data lines and finds edges, start and stop
`timescale 1ns/1ps
`default_nettype none

module smb_frontend
    import expander_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic smb_clk,
    input wire logic smb_data_in,
    smb_events_if.front ev
);

    // ------------------------------------------------------------
    // two-stage synchronisers plus one history stage
    // ------------------------------------------------------------
    logic scl_meta_q, scl_sync_q, scl_prev_q;
    logic sda_meta_q, sda_sync_q, sda_prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_meta_q <= 1'b1;
            scl_sync_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_sync_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= smb_clk;
            scl_sync_q <= scl_meta_q;
            scl_prev_q <= scl_sync_q;
            sda_meta_q <= smb_data_in;
            sda_sync_q <= sda_meta_q;
            sda_prev_q <= sda_sync_q;
        end
    end

    // start and stop are data moves while the clock stays high
    assign ev.scl_rise = scl_sync_q & ~scl_prev_q;
    assign ev.scl_fall = ~scl_sync_q & scl_prev_q;
    assign ev.start = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
    assign ev.stop = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;
    assign ev.sda = sda_sync_q;

endmodule

`default_nettype wire

// file: core/io_expander.sv
// register and command core of the eight-line dual-bank serial i/o expander
`timescale 1ns/1ps
`default_nettype none

// Operation
// - six bank registers plus one readback register
// - suspend_select low applies suspend bank, high applies normal bank, no bus wait
// - one bank supplies both the pin levels and the two masks
// - each active level bit drives its own pin low or releases it
// - variant parameter picks pins low or released after power-up
// - second register masks rising edges, third masks falling edges
// - all edge masks set after power-up in both banks
// - readback returns real pin levels, not stored levels
// - pins captured at the ack fall of the read address byte
// - writes to read-only codes land in normal_output_level
// - bytes move most significant bit first, bit 7 is pin 7
// - resample_straps_cmd send-byte reloads the slave address from straps
// - resample in read or write byte still resamples, data to normal level
// - soft_reset_cmd resamples straps and restores all six bank registers
// - soft reset in read or write byte still resets, data redirected
// - maker_ident_cmd read returns ident byte, write goes to normal level
// - ack is 0, nack is 1; host nacks its last read byte
// - level bit 0 drives pin low, 1 releases it
// - mask bit 0 allows the edge interrupt, 1 suppresses it
// - command codes 00h-05h banks, 06h readback, 07h, 08h, FEh
module io_expander
    import expander_pkg::*;
#(
    parameter bit DRIVE_LOW_AT_POWERUP = 1'b1,
    // arbitrary neutral value
    parameter logic [7:0] MAKER_IDENT = 8'hA5
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic smb_clk,
    input wire logic smb_data_in,
    output logic smb_data_out,
    output logic smb_data_oe,
    input wire logic suspend_select,
    input wire logic [6:0] strap_addr,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic [7:0] io_oe,
    output logic [7:0] rise_mask_active,
    output logic [7:0] fall_mask_active
);

    localparam logic [7:0] LEVEL_RST = DRIVE_LOW_AT_POWERUP ? LEVEL_RST_DRIVE_LOW
                                                            : LEVEL_RST_RELEASED;

    // ------------------------------------------------------------
    // serial front end
    // ------------------------------------------------------------
    smb_events_if ev ();

    smb_frontend u_front (
        .clk(clk),
        .rst_n(rst_n),
        .smb_clk(smb_clk),
        .smb_data_in(smb_data_in),
        .ev(ev)
    );

    // ------------------------------------------------------------
    // pin, suspend and strap synchronisers
    // ------------------------------------------------------------
    logic [7:0] io_meta_q, io_sync_q;
    logic susp_meta_q, susp_sync_q;
    logic [6:0] strap_meta_q, strap_sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_meta_q <= 8'h00;
            io_sync_q <= 8'h00;
            susp_meta_q <= 1'b1;
            susp_sync_q <= 1'b1;
            strap_meta_q <= 7'h00;
            strap_sync_q <= 7'h00;
        end else begin
            io_meta_q <= io_in;
            io_sync_q <= io_meta_q;
            susp_meta_q <= suspend_select;
            susp_sync_q <= susp_meta_q;
            strap_meta_q <= strap_addr;
            strap_sync_q <= strap_meta_q;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t state_q, state_d;
    logic [BIT_COUNT_W-1:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] tx_q, tx_d;
    logic rw_q, rw_d;
    logic [7:0] pointer_q, pointer_d;
    logic [6:0] own_addr_q, own_addr_d;
    logic [1:0] boot_q, boot_d;
    logic [7:0] bank_q [BANK_REGS];
    logic [7:0] bank_d [BANK_REGS];
    logic [7:0] readback_q, readback_d;
    logic sda_oe_q, sda_oe_d;
    logic [7:0] io_oe_q, io_oe_d;
    logic [7:0] rise_q, rise_d;
    logic [7:0] fall_q, fall_d;
    logic [7:0] tx_byte;
    logic [7:0] live_level;

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    always_comb begin
        tx_byte = 8'h00;
        if (pointer_q < CMD_PIN_LEVEL_READBACK) begin
            tx_byte = bank_q[pointer_q[2:0]];
        end else if (pointer_q == CMD_PIN_LEVEL_READBACK) begin
            tx_byte = io_sync_q;
        end else if (pointer_q == CMD_MAKER_IDENT) begin
            tx_byte = MAKER_IDENT;
        end
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        rw_d = rw_q;
        pointer_d = pointer_q;
        own_addr_d = own_addr_q;
        boot_d = boot_q;
        bank_d = bank_q;
        readback_d = readback_q;
        sda_oe_d = sda_oe_q;

        // straps are taken once the synchroniser has filled after reset
        if (boot_q != STRAP_SETTLE) begin
            boot_d = boot_q + 2'h1;
            if (boot_q == STRAP_SETTLE - 2'h1) begin
                own_addr_d = strap_sync_q;
            end
        end

        if (ev.stop) begin
            state_d = ST_IDLE;
            sda_oe_d = 1'b0;
        end else if (ev.start) begin
            state_d = ST_ADDR;
            cnt_d = '0;
            sda_oe_d = 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_CMD, ST_DATA: begin
                    if (ev.scl_rise && cnt_q != BITS_PER_BYTE) begin
                        shift_d = {shift_q[6:0], ev.sda};
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (ev.scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_d = '0;
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == own_addr_q) begin
                                rw_d = shift_q[0];
                                sda_oe_d = 1'b1;
                                state_d = ST_ADDR_ACK;
                            end else begin
                                state_d = ST_IGNORE;
                            end
                        end else if (state_q == ST_CMD) begin
                            sda_oe_d = 1'b1;
                            state_d = ST_CMD_ACK;
                        end else begin
                            sda_oe_d = 1'b1;
                            state_d = ST_DATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (ev.scl_fall) begin
                        if (rw_q) begin
                            readback_d = io_sync_q;
                            tx_d = tx_byte;
                            sda_oe_d = ~tx_byte[7];
                            state_d = ST_TX;
                        end else begin
                            sda_oe_d = 1'b0;
                            state_d = ST_CMD;
                        end
                    end
                end
                ST_CMD_ACK: begin
                    if (ev.scl_fall) begin
                        sda_oe_d = 1'b0;
                        pointer_d = shift_q;
                        if (shift_q == CMD_RESAMPLE_STRAPS) begin
                            own_addr_d = strap_sync_q;
                        end else if (shift_q == CMD_SOFT_RESET) begin
                            own_addr_d = strap_sync_q;
                            bank_d[IDX_NORMAL_OUTPUT_LEVEL] = LEVEL_RST;
                            bank_d[IDX_NORMAL_RISE_MASK] = MASK_RST;
                            bank_d[IDX_NORMAL_FALL_MASK] = MASK_RST;
                            bank_d[IDX_SUSPEND_OUTPUT_LEVEL] = LEVEL_RST;
                            bank_d[IDX_SUSPEND_RISE_MASK] = MASK_RST;
                            bank_d[IDX_SUSPEND_FALL_MASK] = MASK_RST;
                        end
                        state_d = ST_DATA;
                    end
                end
                ST_DATA_ACK: begin
                    if (ev.scl_fall) begin
                        sda_oe_d = 1'b0;
                        // the update lands right after the data byte's ack clock
                        if (pointer_q < CMD_PIN_LEVEL_READBACK) begin
                            bank_d[pointer_q[2:0]] = shift_q;
                        end else begin
                            bank_d[IDX_NORMAL_OUTPUT_LEVEL] = shift_q;
                        end
                        state_d = ST_IGNORE;
                    end
                end
                ST_TX: begin
                    if (ev.scl_fall) begin
                        if (cnt_q == LAST_TX_BIT) begin
                            sda_oe_d = 1'b0;
                            state_d = ST_TX_ACK;
                        end else begin
                            tx_d = {tx_q[6:0], 1'b0};
                            sda_oe_d = ~tx_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    // one byte per read; the host nacks and stops
                    if (ev.scl_rise) begin
                        state_d = ST_IGNORE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin and mask outputs from the live bank
    // ------------------------------------------------------------
    always_comb begin
        if (susp_sync_q) begin
            live_level = bank_d[IDX_NORMAL_OUTPUT_LEVEL];
            rise_d = bank_d[IDX_NORMAL_RISE_MASK];
            fall_d = bank_d[IDX_NORMAL_FALL_MASK];
        end else begin
            live_level = bank_d[IDX_SUSPEND_OUTPUT_LEVEL];
            rise_d = bank_d[IDX_SUSPEND_RISE_MASK];
            fall_d = bank_d[IDX_SUSPEND_FALL_MASK];
        end
        io_oe_d = ~live_level;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            pointer_q <= POINTER_RST;
            own_addr_q <= OWN_ADDR_RST;
            boot_q <= 2'h0;
            bank_q[IDX_NORMAL_OUTPUT_LEVEL] <= LEVEL_RST;
            bank_q[IDX_NORMAL_RISE_MASK] <= MASK_RST;
            bank_q[IDX_NORMAL_FALL_MASK] <= MASK_RST;
            bank_q[IDX_SUSPEND_OUTPUT_LEVEL] <= LEVEL_RST;
            bank_q[IDX_SUSPEND_RISE_MASK] <= MASK_RST;
            bank_q[IDX_SUSPEND_FALL_MASK] <= MASK_RST;
            readback_q <= 8'h00;
            sda_oe_q <= 1'b0;
            io_oe_q <= ~LEVEL_RST;
            rise_q <= MASK_RST;
            fall_q <= MASK_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            rw_q <= rw_d;
            pointer_q <= pointer_d;
            own_addr_q <= own_addr_d;
            boot_q <= boot_d;
            bank_q <= bank_d;
            readback_q <= readback_d;
            sda_oe_q <= sda_oe_d;
            io_oe_q <= io_oe_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    // both open-drain outputs only ever pull low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smb_data_out <= 1'b0;
            io_out <= 8'h00;
        end else begin
            smb_data_out <= 1'b0;
            io_out <= 8'h00;
        end
    end

    assign smb_data_oe = sda_oe_q;
    assign io_oe = io_oe_q;
    assign rise_mask_active = rise_q;
    assign fall_mask_active = fall_q;

endmodule

`default_nettype wire

// file: test/io_expander_monitor.sv
// concurrent checks on the ports of the expander core
`timescale 1ns/1ps
`default_nettype none
module io_expander_monitor #(
    parameter bit DRIVE_LOW_AT_POWERUP = 1'b1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic smb_clk,
    input wire logic smb_data_in,
    input wire logic smb_data_out,
    input wire logic smb_data_oe,
    input wire logic suspend_select,
    input wire logic [6:0] strap_addr,
    input wire logic [7:0] io_in,
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe,
    input wire logic [7:0] rise_mask_active,
    input wire logic [7:0] fall_mask_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // cycles since the bank select or the serial clock last moved
    // ------------------------------------------------------------
    logic [3:0] quiet_q, quiet_d;
    logic sel_q, scl_q;
    always_comb begin
        quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
        if (suspend_select != sel_q || smb_clk != scl_q) begin
            quiet_d = 4'h0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_q <= 4'h0;
            sel_q <= 1'b0;
            scl_q <= 1'b0;
        end else begin
            quiet_q <= quiet_d;
            sel_q <= suspend_select;
            scl_q <= smb_clk;
        end
    end
    localparam logic [7:0] OE_RST = DRIVE_LOW_AT_POWERUP ? 8'hFF : 8'h00;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_out_low; io_out == 8'h00; endproperty
    a_out_low: assert property (p_out_low) else $error("pin output level not low");
    property p_sda_low; smb_data_out == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data output level not low");
    property p_rst_level;
        @(posedge clk) disable iff (1'b0) !rst_n ##1 !rst_n |-> io_oe == OE_RST;
    endproperty
    a_rst_level: assert property (p_rst_level) else $error("pin drive wrong in reset");
    property p_rst_mask;
        @(posedge clk) disable iff (1'b0)
        !rst_n ##1 !rst_n |-> rise_mask_active == 8'hFF && fall_mask_active == 8'hFF;
    endproperty
    a_rst_mask: assert property (p_rst_mask) else $error("masks open in reset");
    property p_rst_sda;
        @(posedge clk) disable iff (1'b0) !rst_n ##1 !rst_n |-> !smb_data_oe;
    endproperty
    a_rst_sda: assert property (p_rst_sda) else $error("data pulled in reset");
    // a write lands a few cycles after a clock fall, so only long quiet spells count
    property p_quiet;
        quiet_q >= 4'h8 |-> $stable(io_oe) && $stable(rise_mask_active)
            && $stable(fall_mask_active);
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs moved with no cause");
    property p_oe_clk_low; $changed(smb_data_oe) |-> !smb_clk; endproperty
    a_oe_clk_low: assert property (p_oe_clk_low) else $error("data moved with clock high");
    property p_ack_hold; $rose(smb_data_oe) |-> smb_data_oe[*7]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("low bit not held a clock");
    c_ack: cover property ($rose(smb_data_oe));
    c_suspend: cover property ($fell(suspend_select));
    c_level: cover property ($changed(io_oe));
endmodule
bind io_expander io_expander_monitor #(.DRIVE_LOW_AT_POWERUP(DRIVE_LOW_AT_POWERUP)) i_mon (
    .clk(clk), .rst_n(rst_n), .smb_clk(smb_clk), .smb_data_in(smb_data_in),
    .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe),
    .suspend_select(suspend_select), .strap_addr(strap_addr), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .rise_mask_active(rise_mask_active),
    .fall_mask_active(fall_mask_active));
`default_nettype wire

// file: test/smb_host_model.sv
// serial bus host that clocks transfers into the expander
`timescale 1ns/1ps
`default_nettype none
module smb_host_model (
    input wire logic clk,
    input wire logic smb_data_oe,
    output logic smb_clk,
    output logic smb_data_in
);
    logic sda_q = 1'b1;
    // pull-up on the wire: released reads high, device pulls it low
    assign smb_data_in = sda_q & ~smb_data_oe;
    initial smb_clk = 1'b1;
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data moves only while the clock is low; clock idles high between frames
    task automatic bit_io(input logic b, output logic r);
        sda_q = b;
        wt(2);
        smb_clk = 1'b1;
        wt(4);
        r = smb_data_in;
        smb_clk = 1'b0;
        wt(2);
    endtask
    task automatic start();
        sda_q = 1'b1;
        wt(2);
        smb_clk = 1'b1;
        wt(4);
        sda_q = 1'b0;
        wt(4);
        smb_clk = 1'b0;
        wt(2);
    endtask
    task automatic stop();
        sda_q = 1'b0;
        wt(2);
        smb_clk = 1'b1;
        wt(4);
        sda_q = 1'b1;
        wt(4);
    endtask
    task automatic byte_tx(input logic [7:0] b, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        if (r !== 1'b0) ok = 1'b0;
    endtask
    task automatic byte_rx(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
            input logic snd, output logic ok);
        ok = 1'b1;
        start();
        byte_tx({a, 1'b0}, ok);
        byte_tx(c, ok);
        if (!snd) byte_tx(d, ok);
        stop();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic rcv,
            output logic [7:0] d, output logic ok);
        ok = 1'b1;
        if (!rcv) begin
            start();
            byte_tx({a, 1'b0}, ok);
            byte_tx(c, ok);
        end
        start();
        byte_tx({a, 1'b1}, ok);
        byte_rx(d);
        stop();
    endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench of the dual-bank expander core
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import expander_pkg::*;
    localparam logic [7:0] IDENT = 8'h3C; // arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic suspend_select = 1'b1;
    logic [6:0] strap_addr = 7'h2A;
    logic [7:0] io_in = 8'h00;
    logic smb_clk, smb_data_in, smb_data_out, smb_data_oe;
    logic [7:0] io_out, io_oe, rise_mask_active, fall_mask_active, oe_hz;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] expv [6];
    logic [15:0] seed = 16'h1C27;
    logic [7:0] d;
    logic ok;
    logic [6:0] adr = 7'h2A;
    always #50 clk = ~clk;
    io_expander #(.DRIVE_LOW_AT_POWERUP(1'b1), .MAKER_IDENT(IDENT)) i_io_expander (
        .clk(clk), .rst_n(rst_n), .smb_clk(smb_clk), .smb_data_in(smb_data_in),
        .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe),
        .suspend_select(suspend_select), .strap_addr(strap_addr), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .rise_mask_active(rise_mask_active),
        .fall_mask_active(fall_mask_active));
    io_expander #(.DRIVE_LOW_AT_POWERUP(1'b0), .MAKER_IDENT(IDENT)) i_io_expander_hz (
        .clk(clk), .rst_n(rst_n), .smb_clk(smb_clk), .smb_data_in(smb_data_in),
        .smb_data_out(), .smb_data_oe(), .suspend_select(suspend_select),
        .strap_addr(strap_addr), .io_in(io_in), .io_out(), .io_oe(oe_hz),
        .rise_mask_active(), .fall_mask_active());
    smb_host_model i_smb_host_model (.clk(clk), .smb_data_oe(smb_data_oe),
        .smb_clk(smb_clk), .smb_data_in(smb_data_in));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // pins left released follow the outside level, driven pins read low
    function automatic logic [7:0] pins(input logic [7:0] v, input logic [7:0] lvl);
        return v & lvl;
    endfunction
    function automatic logic [7:0] rst_val(input int i);
        return (i % 3 == 0) ? LEVEL_RST_DRIVE_LOW : MASK_RST;
    endfunction
    task automatic report_and_stop();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_ack(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t ack got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        for (int i = 0; i < 6; i++) expv[i] = rst_val(i);
    endtask
    task automatic check_all();
        for (int i = 0; i < 6; i++) begin
            i_smb_host_model.rd(adr, 8'(i), 1'b0, d, ok);
            chk8(d, expv[i]);
        end
    endtask
    task automatic poke(input int i);
        seed = lfsr(seed);
        expv[i] = seed[7:0];
        i_smb_host_model.wr(adr, 8'(i), expv[i], 1'b0, ok);
        chk_ack(ok, 1'b1);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        do_reset();
        chk8(io_oe, 8'hFF);
        chk8(oe_hz, 8'h00);
        chk8(rise_mask_active, MASK_RST);
        chk8(fall_mask_active, MASK_RST);
        i_smb_host_model.rd(adr, 8'h00, 1'b1, d, ok);
        chk8(d, LEVEL_RST_DRIVE_LOW);
        i_smb_host_model.wr(7'h11, 8'h00, 8'h5A, 1'b0, ok);
        chk_ack(ok, 1'b0);
        for (int i = 0; i < 6; i++) poke(i);
        check_all();
        for (int s = 1; s >= 0; s--) begin
            suspend_select = s[0];
            repeat (6) @(negedge clk);
            chk8(io_oe, ~expv[3 - 3 * s]);
            chk8(rise_mask_active, expv[4 - 3 * s]);
            chk8(fall_mask_active, expv[5 - 3 * s]);
        end
        suspend_select = 1'b1;
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            io_in = pins(seed[7:0], expv[0]);
            i_smb_host_model.rd(adr, CMD_PIN_LEVEL_READBACK, k[0], d, ok);
            chk8(d, pins(seed[7:0], expv[0]));
        end
        expv[0] = 8'hC3;
        i_smb_host_model.wr(adr, CMD_PIN_LEVEL_READBACK, 8'hC3, 1'b0, ok);
        check_all();
        i_smb_host_model.rd(adr, CMD_MAKER_IDENT, 1'b0, d, ok);
        chk8(d, IDENT);
        expv[0] = 8'h96;
        i_smb_host_model.wr(adr, CMD_MAKER_IDENT, 8'h96, 1'b0, ok);
        repeat (6) @(negedge clk);
        chk8(io_oe, 8'h69);
        strap_addr = 7'h35;
        i_smb_host_model.wr(adr, CMD_RESAMPLE_STRAPS, 8'h00, 1'b1, ok);
        chk_ack(ok, 1'b1);
        i_smb_host_model.wr(adr, 8'h00, 8'h11, 1'b0, ok);
        chk_ack(ok, 1'b0);
        adr = 7'h35;
        strap_addr = 7'h4B;
        expv[0] = 8'h5E;
        i_smb_host_model.wr(adr, CMD_RESAMPLE_STRAPS, 8'h5E, 1'b0, ok);
        adr = 7'h4B;
        check_all();
        poke(4);
        for (int i = 0; i < 6; i++) expv[i] = rst_val(i);
        expv[0] = 8'h24;
        i_smb_host_model.wr(adr, CMD_SOFT_RESET, 8'h24, 1'b0, ok);
        check_all();
        poke(1);
        for (int i = 0; i < 6; i++) expv[i] = rst_val(i);
        i_smb_host_model.wr(adr, CMD_SOFT_RESET, 8'h00, 1'b1, ok);
        check_all();
        poke(0);
        do_reset();
        chk8(io_oe, 8'hFF);
        report_and_stop();
    end
endmodule
`default_nettype wire
